// File: pnp_card_control.v
// plug and play card state machine and card control registers
`timescale 1ns/10ps
`include "pnp_card_defines.vh"
module pnp_card_control (
  input  wire        clk_sys,      // isa bus clock
  input  wire        rst,          // bus reset, sync active high
  input  wire        addr_wr,      // write strobe to address port
  input  wire        data_wr,      // write strobe to write data port
  input  wire        data_rd,      // read strobe to readback port
  input  wire        other_io,     // any other io cycle
  input  wire [7:0]  wr_data,      // isa write data
  input  wire [1:0]  bus_sense,    // data bits 1:0 seen on the bus
  input  wire [71:0] serial_id,    // card serial identifier
  input  wire [7:0]  rom_data,     // resource byte from eeprom
  input  wire        rom_valid,    // eeprom byte arrived
  output reg  [7:0]  rd_data,      // readback data
  output reg         rd_data_oe,   // drive data bus
  output reg  [11:0] rd_port_addr, // readback port io address
  output reg  [3:0]  card_state,   // one-hot card state
  output reg  [7:0]  card_handle,  // current card handle
  output reg         dev_reset,    // pulse: logical device defaults
  output reg         rom_rewind,   // pulse: pointer to start
  output reg         rom_fetch,    // pulse: fetch next byte
  output reg  [1:0]  mem_desc_en   // memory descriptors present
);
  // one-hot card states
  localparam [3:0] ST_WFK   = 4'b0001;
  localparam [3:0] ST_SLEEP = 4'b0010;
  localparam [3:0] ST_ISO   = 4'b0100;
  localparam [3:0] ST_CFG   = 4'b1000;

  reg  [7:0]  index_r;
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [7:0]  handle_r;
  reg  [7:0]  rdport_r;
  reg  [6:0]  bit_r;
  reg         phase_r;
  reg         lost_r;
  reg         sense_ok_r;
  reg  [7:0]  res_byte_r;
  reg         res_ready_r;
  wire        key_ok;
  wire        iso_bit;
  wire        wr_cmd;
  wire        rd_iso;
  wire        do_wfk;

  // decode one index against the held address
  function is_idx;
    input [7:0] held;
    input [7:0] want;
    begin
      is_idx = (held == want);
    end
  endfunction

  pnp_init_key u_key (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .restart  (state_r != ST_WFK),
    .addr_wr  (addr_wr),
    .other_io (other_io),
    .wr_data  (wr_data),
    .key_ok   (key_ok)
  );

  assign wr_cmd  = data_wr && state_r != ST_WFK;
  assign rd_iso  = data_rd && state_r == ST_ISO
                   && is_idx(index_r, `IDX_ISOLATION);
  assign iso_bit = serial_id[bit_r];
  assign do_wfk  = wr_cmd && is_idx(index_r, `IDX_CONFIG_CMD)
                   && wr_data[`CMD_WFK_BIT];

  // index held across any number of data accesses
  always @(posedge clk_sys)
  begin
    if (rst)
      index_r <= 8'h00;
    else if (addr_wr && state_r != ST_WFK)
      index_r <= wr_data;
  end

  // card state transitions
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_WFK:
        if (key_ok)
          state_nxt = ST_SLEEP;
      ST_SLEEP, ST_ISO, ST_CFG:
        if (do_wfk)
          state_nxt = ST_WFK;
        else if (wr_cmd && is_idx(index_r, `IDX_WAKE))
        begin
          // only a sleeping card with a matching handle moves
          if (state_r == ST_SLEEP && wr_data == handle_r)
            state_nxt = (wr_data == 8'h00) ? ST_ISO : ST_CFG;
        end
        else if (state_r == ST_ISO && lost_r)
          state_nxt = ST_SLEEP;
        else if (wr_cmd && state_r == ST_ISO
                 && is_idx(index_r, `IDX_HANDLE))
          state_nxt = ST_CFG;
      default:
        state_nxt = ST_WFK;
    endcase
  end

  // state, handle and readback port registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r  <= ST_WFK;
      handle_r <= `HANDLE_RESET;
      rdport_r <= `READBACK_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      if (wr_cmd && is_idx(index_r, `IDX_READBACK))
        rdport_r <= wr_data;
      if (wr_cmd && is_idx(index_r, `IDX_HANDLE))
        handle_r <= wr_data;
      else if (wr_cmd && is_idx(index_r, `IDX_CONFIG_CMD)
               && wr_data[`CMD_HANDLE_BIT])
        handle_r <= 8'h00;
    end
  end

  // isolation bit walk: 72 read pairs
  always @(posedge clk_sys)
  begin
    if (rst || state_r != ST_ISO || state_nxt != ST_ISO)
    begin
      bit_r      <= 7'd0;
      phase_r    <= 1'b0;
      lost_r     <= 1'b0;
      sense_ok_r <= 1'b0;
    end
    else if (rd_iso)
    begin
      phase_r <= ~phase_r;
      if (!phase_r)
        sense_ok_r <= iso_bit || bus_sense == 2'b01;
      else
      begin
        if (!iso_bit && sense_ok_r && bus_sense == 2'b10)
          lost_r <= 1'b1;
        if (bit_r != `SERIAL_BITS - 7'd1)
          bit_r <= bit_r + 7'd1;
      end
    end
  end

  // resource byte register and ready flag
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      res_byte_r  <= 8'h00;
      res_ready_r <= 1'b0;
    end
    else if (wr_cmd && is_idx(index_r, `IDX_WAKE))
      res_ready_r <= 1'b0;
    else if (rom_valid)
    begin
      res_byte_r  <= rom_data;
      res_ready_r <= 1'b1;
    end
    else if (data_rd && state_r == ST_CFG
             && is_idx(index_r, `IDX_RESOURCE))
      res_ready_r <= 1'b0;
  end

  // registered outputs: readback data and command pulses
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rd_data      <= 8'h00;
      rd_data_oe   <= 1'b0;
      rd_port_addr <= {`RD_PORT_HI, `READBACK_RESET, `RD_PORT_LO};
      card_state   <= ST_WFK;
      card_handle  <= `HANDLE_RESET;
      dev_reset    <= 1'b1;
      rom_rewind   <= 1'b1;
      rom_fetch    <= 1'b0;
      mem_desc_en  <= 2'b00;
    end
    else
    begin
      rd_port_addr <= {`RD_PORT_HI, rdport_r, `RD_PORT_LO};
      card_state   <= state_r;
      card_handle  <= handle_r;
      mem_desc_en  <= {`MEM_DESC_COUNT{1'b1}};
      // self-clearing: pulses last one cycle only
      dev_reset  <= wr_cmd && is_idx(index_r, `IDX_CONFIG_CMD)
                    && wr_data[`CMD_RESET_BIT];
      rom_rewind <= wr_cmd && is_idx(index_r, `IDX_WAKE);
      rom_fetch  <= data_rd && state_r == ST_CFG
                    && is_idx(index_r, `IDX_RESOURCE);
      rd_data_oe <= 1'b0;
      rd_data    <= 8'h00;
      if (data_rd && state_r != ST_WFK && state_r != ST_SLEEP)
      begin
        case (index_r)
          `IDX_ISOLATION:
            if (state_r == ST_ISO && iso_bit)
            begin
              rd_data_oe <= 1'b1;
              rd_data    <= phase_r ? `ISO_SECOND : `ISO_FIRST;
            end
          `IDX_RESOURCE:
          begin
            rd_data_oe <= 1'b1;
            rd_data    <= res_byte_r;
          end
          `IDX_READY:
          begin
            rd_data_oe <= 1'b1;
            rd_data    <= {7'd0, res_ready_r};
          end
          `IDX_HANDLE:
          begin
            rd_data_oe <= 1'b1;
            rd_data    <= handle_r;
          end
          `IDX_LOGICAL:
          begin
            rd_data_oe <= 1'b1;
            rd_data    <= `LOGICAL_VALUE;
          end
          default:
            rd_data_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule // pnp_card_control

// File: pnp_card_defines.vh
// card control constants and index map for the plug and play card logic
//
// Operation
// - bus reset: wait for key, handle zero, defaults
// - return command sends card to wait for key
// - index 0x00 sets readback address bits 9:2
// - reads of readback location have no effect
// - isolation read evaluates one serial id bit
// - control bit 0 resets device, keeps handle
// - control bit 1 to wait for key, keep all
// - control bit 2 clears card handle
// - control write-only, command bits self-clearing
// - matching wake moves sleep to isolation/config
// - wake write rewinds resource pointer
// - resource read in config returns next byte, advances
// - status bit 0 set when byte ready
// - handle register writable and readable
// - logical unit index always reads zero
// - only two memory descriptors provided
// - index persists across data accesses
// - key sequence leaves wait for key; else restart
// - isolation drives 55/aa pair or senses bits
`ifndef PNP_CARD_DEFINES_VH
`define PNP_CARD_DEFINES_VH
`define IDX_READBACK    8'h00
`define IDX_ISOLATION   8'h01
`define IDX_CONFIG_CMD  8'h02
`define IDX_WAKE        8'h03
`define IDX_RESOURCE    8'h04
`define IDX_READY       8'h05
`define IDX_HANDLE      8'h06
`define IDX_LOGICAL     8'h07
`define CMD_RESET_BIT   0
`define CMD_WFK_BIT     1
`define CMD_HANDLE_BIT  2
`define READY_BIT       0
`define RD_PORT_HI      2'b00
`define RD_PORT_LO      2'b11
`define ISO_FIRST       8'h55
`define ISO_SECOND      8'haa
`define LOGICAL_VALUE   8'h00
`define KEY_LEN         6'd32
`define KEY_FIRST       8'h6a
`define SERIAL_BITS     7'd72
`define MEM_DESC_COUNT  2
`define ROM_LATENCY     4'd4
`define HANDLE_RESET    8'h00
`define READBACK_RESET  8'h00
`endif

// File: pnp_init_key.v
// initiation key detector, lfsr based
`timescale 1ns/10ps
`include "pnp_card_defines.vh"
module pnp_init_key (
  input  wire       clk_sys,   // system clock
  input  wire       rst,       // sync reset
  input  wire       restart,   // force back to first byte
  input  wire       addr_wr,   // address port write
  input  wire       other_io,  // any other io access
  input  wire [7:0] wr_data,   // written byte
  output reg        key_ok     // one-cycle key detected
);
  reg  [7:0] expect_r;
  reg  [5:0] count_r;
  wire [7:0] lfsr_nxt;

  // next key byte from the pattern lfsr
  assign lfsr_nxt = {expect_r[1] ^ expect_r[0], expect_r[7:1]};

  // sequential compare; any mismatch or other access restarts
  always @(posedge clk_sys)
  begin
    if (rst || restart || other_io)
    begin
      expect_r <= `KEY_FIRST;
      count_r  <= 6'd0;
      key_ok   <= 1'b0;
    end
    else if (addr_wr && wr_data == expect_r)
    begin
      if (count_r == `KEY_LEN - 6'd1)
      begin
        key_ok   <= 1'b1;
        count_r  <= 6'd0;
        expect_r <= `KEY_FIRST;
      end
      else
      begin
        key_ok   <= 1'b0;
        count_r  <= count_r + 6'd1;
        expect_r <= lfsr_nxt;
      end
    end
    else if (addr_wr)
    begin
      key_ok   <= 1'b0;
      count_r  <= 6'd0;
      expect_r <= `KEY_FIRST;
    end
    else
      key_ok <= 1'b0;
  end
endmodule // pnp_init_key

// File: pnp_card_checker_properties.sv
// concurrent checks on the card control ports
`timescale 1ns/10ps
module pnp_card_checker (
  input wire        clk_sys,      // clock
  input wire        rst,          // reset
  input wire        data_wr,      // data write
  input wire        data_rd,      // data read
  input wire [7:0]  rd_data,      // read data
  input wire        rd_data_oe,   // bus drive
  input wire [11:0] rd_port_addr, // read port
  input wire [3:0]  card_state,   // state
  input wire [7:0]  card_handle,  // handle
  input wire        dev_reset,    // device reset
  input wire        rom_rewind,   // rewind pulse
  input wire        rom_fetch,    // fetch pulse
  input wire [1:0]  mem_desc_en   // descriptors
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // reset values, fixed shapes
  a_reset_values: assert property (disable iff (1'b0)
    rst |=> card_state == 4'h1 && card_handle == 8'h00)
    else $error("reset values wrong");
  a_port_shape: assert property (
    rd_port_addr[11:10] == 2'b00 && rd_port_addr[1:0] == 2'b11)
    else $error("read port fixed bits wrong");
  a_desc_pair: assert property (!$past(rst) |-> mem_desc_en == 2'b11)
    else $error("descriptor count wrong");
  // bus drive only as answer to a read
  a_oe_cause: assert property (rd_data_oe |-> $past(data_rd))
    else $error("drive without read");
  a_iso_bytes: assert property (rd_data_oe && card_state == 4'h4
    |-> rd_data == 8'h55 || rd_data == 8'haa)
    else $error("isolation byte wrong");
  a_wait_quiet: assert property (
    card_state == 4'h1 && data_rd |=> !rd_data_oe)
    else $error("drive while waiting for key");
  // outputs change only after their cause
  a_handle_cause: assert property (
    $changed(card_handle) |-> $past(data_wr) || $past(data_wr, 2))
    else $error("handle changed without write");
  a_rewind_cause: assert property (
    rom_rewind |-> $past(data_wr) || $past(rst))
    else $error("rewind without write");
  a_fetch_cause: assert property (
    rom_fetch |-> rd_data_oe && $past(data_rd))
    else $error("fetch without read");
  a_devrst_cause: assert property (
    dev_reset |-> $past(data_wr) || $past(rst))
    else $error("device reset without write");
  // main scenarios reached
  c_isolation: cover property (card_state == 4'h4);
  c_second_byte: cover property (rd_data_oe && rd_data == 8'haa);
  c_dev_reset: cover property (dev_reset && !$past(rst));
endmodule // pnp_card_checker
bind pnp_card_control pnp_card_checker i_chk (.clk_sys, .rst, .data_wr,
  .data_rd, .rd_data, .rd_data_oe, .rd_port_addr, .card_state, .card_handle,
  .dev_reset, .rom_rewind, .rom_fetch, .mem_desc_en);

// File: pnp_host_model.sv
// host model: configuration software on the plug and play ports
`timescale 1ns/10ps
module pnp_host_model (
  input  wire       clk_sys,  // clock
  input  wire [7:0] rd_data,  // card data
  input  wire       rd_oe,    // card drives
  output reg        addr_wr,  // address write
  output reg        data_wr,  // data write
  output reg        data_rd,  // data read
  output reg        other_io, // other cycle
  output reg  [7:0] wr_data   // write byte
);
  initial {addr_wr, data_wr, data_rd, other_io, wr_data} = 12'h000;
  // one write: address port when a is set, else data port
  task put(input logic a, input logic [7:0] d);
    @(posedge clk_sys);
    addr_wr <= a;
    data_wr <= !a;
    wr_data <= d;
    @(posedge clk_sys);
    {addr_wr, data_wr} <= 2'b00;
  endtask
  // one read, answer taken a cycle later as {oe, data}
  task get(output logic [8:0] r);
    @(posedge clk_sys);
    data_rd <= 1'b1;
    @(posedge clk_sys);
    data_rd <= 1'b0;
    #1 r = {rd_oe, rd_data};
  endtask
  // unrelated io cycle, restarts key checking
  task other;
    @(posedge clk_sys);
    other_io <= 1'b1;
    @(posedge clk_sys);
    other_io <= 1'b0;
  endtask
  // first n key bytes back to back, lfsr from 6a
  task key(input int n);
    logic [7:0] k;
    k = 8'h6a;
    repeat (n)
    begin
      @(posedge clk_sys);
      addr_wr <= 1'b1;
      wr_data <= k;
      k = {k[1] ^ k[0], k[7:1]};
    end
    @(posedge clk_sys);
    addr_wr <= 1'b0;
  endtask
  // resource byte: poll ready bit, then read
  task res_rd(output logic [8:0] r);
    put(1'b1, 8'h05);
    r = 9'h000;
    for (int i = 0; i < 20 && !r[0]; i++)
      get(r);
    put(1'b1, 8'h04);
    get(r);
  endtask
endmodule // pnp_host_model

// File: isa_pnp_card_control_tb_top.sv
// self-checking bench for the card control block
`timescale 1ns/10ps
module isa_pnp_card_control_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  bus_sense = 2'b00;
  logic [71:0] serial_id = 72'h0;
  logic [7:0]  rom_data = 8'h00;
  logic        rom_valid = 1'b0;
  wire         addr_wr, data_wr, data_rd, other_io, rd_data_oe;
  wire         dev_reset, rom_rewind, rom_fetch;
  wire  [7:0]  wr_data, rd_data, card_handle;
  wire  [11:0] rd_port_addr;
  wire  [3:0]  card_state;
  wire  [1:0]  mem_desc_en;
  logic [8:0]  r;
  logic [7:0]  h, b;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #25 clk_sys = ~clk_sys;
  pnp_card_control i_pnp_card_control (.clk_sys, .rst, .addr_wr, .data_wr,
    .data_rd, .other_io, .wr_data, .bus_sense, .serial_id, .rom_data,
    .rom_valid, .rd_data, .rd_data_oe, .rd_port_addr, .card_state,
    .card_handle, .dev_reset, .rom_rewind, .rom_fetch, .mem_desc_en);
  pnp_host_model i_pnp_host_model (.clk_sys, .rd_data, .rd_oe(rd_data_oe),
    .addr_wr, .data_wr, .data_rd, .other_io, .wr_data);
  // expected isolation byte and read port address
  function logic [7:0] iso_byte(input logic second);
    return second ? 8'haa : 8'h55;
  endfunction
  function logic [11:0] port_of(input logic [7:0] v);
    return {2'b00, v, 2'b11};
  endfunction
  // compare, count, report
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task settle;
    @(posedge clk_sys);
    #1;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  // main sequence
  initial
  begin
    h = $urandom(58889);
    b = $urandom;
    serial_id <= {$urandom, $urandom, b};
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    settle;
    chk(card_state, 4'h1);
    chk(rd_port_addr, 12'h003);
    chk(mem_desc_en, 2'b11);
    i_pnp_host_model.get(r);
    chk(r[8], 1'b0);
    i_pnp_host_model.key(16);
    i_pnp_host_model.other;
    i_pnp_host_model.key(31);
    i_pnp_host_model.other;
    repeat (3) settle;
    chk(card_state, 4'h1);
    i_pnp_host_model.key(32);
    repeat (3) settle;
    chk(card_state, 4'h2);
    $display("key test done");
    i_pnp_host_model.put(1'b1, 8'h03);
    i_pnp_host_model.put(1'b0, 8'h05);
    repeat (2) settle;
    chk(card_state, 4'h2);
    i_pnp_host_model.put(1'b0, 8'h00);
    #1 chk(rom_rewind, 1'b1);
    settle;
    chk(card_state, 4'h4);
    i_pnp_host_model.put(1'b1, 8'h01);
    for (int i = 0; i < 72; i++)
    begin
      i_pnp_host_model.get(r);
      if (serial_id[i])
        chk(r, {1'b1, iso_byte(1'b0)});
      else
        chk(r[8], 1'b0);
      i_pnp_host_model.get(r);
      if (serial_id[i])
        chk(r, {1'b1, iso_byte(1'b1)});
    end
    $display("isolation test done");
    h = $urandom_range(255, 1);
    i_pnp_host_model.put(1'b1, 8'h06);
    i_pnp_host_model.put(1'b0, h);
    repeat (2) settle;
    chk(card_state, 4'h8);
    i_pnp_host_model.get(r);
    chk(r, {1'b1, h});
    i_pnp_host_model.put(1'b1, 8'h07);
    i_pnp_host_model.put(1'b0, 8'hff);
    i_pnp_host_model.get(r);
    chk(r, 9'h100);
    b = $urandom;
    i_pnp_host_model.put(1'b1, 8'h00);
    i_pnp_host_model.put(1'b0, b);
    settle;
    chk(rd_port_addr, port_of(b));
    i_pnp_host_model.get(r);
    chk(r[8], 1'b0);
    repeat (3)
    begin
      b = $urandom;
      @(posedge clk_sys);
      rom_data <= b;
      rom_valid <= 1'b1;
      @(posedge clk_sys);
      rom_valid <= 1'b0;
      i_pnp_host_model.res_rd(r);
      chk(r, {1'b1, b});
      chk(rom_fetch, 1'b1);
      i_pnp_host_model.put(1'b1, 8'h05);
      i_pnp_host_model.get(r);
      chk(r[0], 1'b0);
    end
    $display("register test done");
    i_pnp_host_model.put(1'b1, 8'h02);
    i_pnp_host_model.put(1'b0, 8'h04);
    settle;
    chk(card_handle, 8'h00);
    i_pnp_host_model.put(1'b1, 8'h06);
    i_pnp_host_model.put(1'b0, h);
    i_pnp_host_model.put(1'b1, 8'h02);
    i_pnp_host_model.put(1'b0, 8'h02);
    repeat (2) settle;
    chk(card_state, 4'h1);
    chk(card_handle, h);
    i_pnp_host_model.key(32);
    i_pnp_host_model.put(1'b1, 8'h03);
    i_pnp_host_model.put(1'b0, h);
    repeat (2) settle;
    chk(card_state, 4'h8);
    i_pnp_host_model.put(1'b1, 8'h03);
    i_pnp_host_model.put(1'b0, ~h);
    repeat (2) settle;
    chk(card_state, 4'h8);
    i_pnp_host_model.put(1'b1, 8'h02);
    i_pnp_host_model.put(1'b0, 8'h01);
    #1 chk(dev_reset, 1'b1);
    chk(card_handle, h);
    settle;
    chk(dev_reset, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle;
    chk(card_state, 4'h1);
    chk(card_handle, 8'h00);
    // losing card: zero id bit, other card seen driving 01 then 10
    serial_id[0] <= 1'b0;
    i_pnp_host_model.key(32);
    i_pnp_host_model.put(1'b1, 8'h03);
    i_pnp_host_model.put(1'b0, 8'h00);
    i_pnp_host_model.put(1'b1, 8'h01);
    bus_sense <= 2'b01;
    i_pnp_host_model.get(r);
    bus_sense <= 2'b10;
    i_pnp_host_model.get(r);
    bus_sense <= 2'b00;
    repeat (2) settle;
    chk(card_state, 4'h2);
    $display("command test done");
    tally_and_finish;
  end
endmodule // isa_pnp_card_control_tb_top
